// ==== core/ckg_ctrl.sv ====
// Clock controller: registers, oscillator modes, dividers, gating
`timescale 1ns/1ps
module ckg_ctrl #(
  parameter int NGATE = 16,
  parameter int OSC_START = ckg_pkg::OSC_START_CYC
) (
  input  wire logic             mclk,
  input  wire logic             rstn,
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [15:0]      paddr,
  input  wire logic [31:0]      pwdata,
  output logic      [31:0]      prdata,
  output logic                  pready,
  output logic                  pslverr,
  input  wire logic             stop_mode,
  input  wire logic             loop_tick,
  input  wire logic             iref_tick,
  input  wire logic             eref_tick,
  input  wire logic             periph_wr_req,
  input  wire logic [NGATE-1:0] periph_wr_sel,
  output logic      [NGATE-1:0] periph_clk_en,
  output logic      [NGATE-1:0] periph_wr_ok,
  output logic                  osc_amp_en,
  output logic                  osc_high_gain,
  output logic                  crystal_output_pin_in_direct,
  output logic                  crystal_output_pin_out_free,
  output logic                  eref_clk_en,
  output logic                  loop_ref_is_int,
  output logic                  loop_ref_tick,
  output logic                  bus_tick,
  output logic                  iref_clk_out,
  output logic                  low_power_1khz_clock
);
  logic [7:0]       src_r;
  logic [7:0]       bus_divider_r;
  logic [7:0]       trim_r;
  logic [7:0]       lock_r;
  logic [7:0]       osc_r;
  logic [7:0]       pwr_r;
  logic [NGATE-1:0] gate_r;
  logic [7:0]       osc_cnt_r;
  logic             osc_rdy_r;
  logic             iref_pre_r;
  ckg_pkg::ckg_osc_mode_t mode;
  logic             wr_en;
  logic             rd_en;
  logic [1:0]       src_sel;
  logic             src_tick;
  logic             ref_src_tick;
  logic [3:0]       reference_divider_exp;
  logic             div_bus;
  logic             div_ref;
  logic [7:0]       stat_val;

  function automatic logic hit(input logic [15:0] a, input logic [15:0] o);
    hit = (a[15:2] == o[15:2]);
  endfunction

  // Registers are byte wide in a 16-bit space; lane picks the byte
  function automatic logic [7:0] lane(input logic [31:0] d,
                                      input logic [15:0] a);
    lane = d[8*a[1:0] +: 8];
  endfunction

  function automatic logic [31:0] place(input logic [7:0] v,
                                        input logic [15:0] a);
    place = {24'h0, v} << (8 * a[1:0]);
  endfunction

  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && !penable && !pwrite;

  always_comb begin
    if (!osc_r[ckg_pkg::OSC_EN] && !osc_r[ckg_pkg::OSC_OS]) begin
      mode = ckg_pkg::OSC_BYPASS;
    end else if (osc_r[ckg_pkg::OSC_EN] && osc_r[ckg_pkg::OSC_OS]) begin
      if (osc_r[ckg_pkg::OSC_HGO]) begin
        mode = ckg_pkg::OSC_HIGAIN;
      end else begin
        mode = ckg_pkg::OSC_LOWPWR;
      end
    end else begin
      mode = ckg_pkg::OSC_OTHER;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      src_r  <= ckg_pkg::RST_SRC;
      bus_divider_r <= ckg_pkg::RST_BUS_DIVIDER;
      lock_r <= ckg_pkg::RST_LOCK;
      pwr_r  <= 8'h00;
    end else if (wr_en) begin
      if (hit(paddr, ckg_pkg::OFS_SRC) && paddr[1:0] == 2'h0) begin
        src_r <= lane(pwdata, paddr);
      end
      if (hit(paddr, ckg_pkg::OFS_BUS_DIVIDER) && paddr[1:0] == 2'h1) begin
        bus_divider_r <= lane(pwdata, paddr) & 8'hf0;
      end
      if (hit(paddr, ckg_pkg::OFS_LOCK) && paddr[1:0] == 2'h3) begin
        lock_r <= lane(pwdata, paddr);
      end
      if (hit(paddr, ckg_pkg::OFS_PWR)) begin
        pwr_r <= pwdata[7:0];
      end
    end
  end

  // Trim has no reset: its value is undefined until software loads it
  always_ff @(posedge mclk) begin
    if (wr_en && hit(paddr, ckg_pkg::OFS_TRIM) && paddr[1:0] == 2'h2) begin
      trim_r <= lane(pwdata, paddr);
    end
  end

  // Ready flag is hardware state; software writes cannot set it
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      osc_r <= ckg_pkg::RST_OSC;
    end else if (wr_en && hit(paddr, ckg_pkg::OFS_OSC)
                 && paddr[1:0] == 2'h2) begin
      osc_r <= lane(pwdata, paddr) & 8'hfe;
    end
  end

  // Start-up wait models crystal settling before the flag rises
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      osc_cnt_r <= 8'h0;
      osc_rdy_r <= 1'b0;
    end else if (!osc_r[ckg_pkg::OSC_EN] || !osc_r[ckg_pkg::OSC_OS]) begin
      osc_cnt_r <= 8'h0;
      osc_rdy_r <= 1'b0;
    end else if (osc_cnt_r == 8'(OSC_START)) begin
      osc_rdy_r <= 1'b1;
    end else if (eref_tick) begin
      osc_cnt_r <= osc_cnt_r + 8'h1;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      gate_r <= '1;
    end else if (wr_en) begin
      if (hit(paddr, ckg_pkg::OFS_GATE0)) begin
        gate_r[NGATE/2-1:0] <= pwdata[NGATE/2-1:0];
      end
      if (hit(paddr, ckg_pkg::OFS_GATE1)) begin
        gate_r[NGATE-1:NGATE/2] <= pwdata[NGATE/2-1:0];
      end
    end
  end

  // Outside stop, gate outputs follow the gating register on the next edge
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      periph_clk_en <= '1;
      periph_wr_ok  <= '0;
    end else begin
      periph_clk_en <= stop_mode ? '0 : gate_r;
      periph_wr_ok  <= periph_wr_req ? (periph_wr_sel & gate_r
                       & {NGATE{!stop_mode}}) : '0;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      osc_amp_en     <= 1'b0;
      osc_high_gain  <= 1'b0;
      crystal_output_pin_in_direct <= 1'b1;
      crystal_output_pin_out_free  <= 1'b1;
      eref_clk_en    <= 1'b0;
    end else begin
      osc_amp_en     <= (mode == ckg_pkg::OSC_LOWPWR)
                        || (mode == ckg_pkg::OSC_HIGAIN);
      osc_high_gain  <= (mode == ckg_pkg::OSC_HIGAIN);
      crystal_output_pin_in_direct <= (mode == ckg_pkg::OSC_BYPASS);
      crystal_output_pin_out_free  <= (mode == ckg_pkg::OSC_BYPASS);
      eref_clk_en    <= osc_r[ckg_pkg::OSC_EN];
    end
  end

  assign src_sel = src_r[ckg_pkg::SRC_SEL_HI:ckg_pkg::SRC_SEL_LO];

  // Reserved code gives no clock rather than guessing a source
  always_comb begin
    case (src_sel)
      ckg_pkg::SRC_LOOP: src_tick = loop_tick;
      ckg_pkg::SRC_IREF: src_tick = iref_tick;
      ckg_pkg::SRC_EREF: src_tick = eref_tick;
      default:           src_tick = 1'b0;
    endcase
  end

  ckg_clk_div #(.EW(4)) u_bus_div (
    .mclk     (mclk),
    .rstn     (rstn),
    .src_tick (src_tick),
    .exp_sel  ({1'b0, bus_divider_r[ckg_pkg::BUS_DIVIDER_HI:ckg_pkg::BUS_DIVIDER_LO]}),
    .out_tick (div_bus)
  );

  assign reference_divider_exp = {1'b0, src_r[ckg_pkg::REFERENCE_DIVIDER_HI:ckg_pkg::REFERENCE_DIVIDER_LO]}
                    + (osc_r[ckg_pkg::OSC_RANGE] ? 4'(ckg_pkg::RANGE_SHIFT)
                       : 4'h0);
  assign ref_src_tick = src_r[ckg_pkg::IREF_SEL] ? 1'b0 : eref_tick;

  ckg_clk_div #(.EW(4)) u_ref_div (
    .mclk     (mclk),
    .rstn     (rstn),
    .src_tick (ref_src_tick),
    .exp_sel  (reference_divider_exp),
    .out_tick (div_ref)
  );

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      bus_tick        <= 1'b0;
      loop_ref_tick   <= 1'b0;
      loop_ref_is_int <= 1'b1;
      iref_clk_out    <= 1'b0;
      iref_pre_r      <= 1'b1;
    end else begin
      bus_tick        <= div_bus && !stop_mode;
      loop_ref_is_int <= src_r[ckg_pkg::IREF_SEL];
      loop_ref_tick   <= src_r[ckg_pkg::IREF_SEL] ? iref_tick
                         : div_ref;
      if (!stop_mode) begin
        iref_pre_r <= src_r[ckg_pkg::IREF_SEL];
      end
      iref_clk_out <= iref_tick && src_r[ckg_pkg::IREF_OEN]
                      && (!stop_mode || (src_r[ckg_pkg::IREF_KEEP]
                      && (src_r[ckg_pkg::IREF_OEN] || iref_pre_r)));
    end
  end

  ckg_lpo u_lpo (
    .mclk    (mclk),
    .rstn    (rstn),
    .lpo_clk (low_power_1khz_clock)
  );

  // Status: source in use, loop reference; read-only
  always_comb begin
    stat_val = 8'h00;
    stat_val[ckg_pkg::STAT_IREFST] = src_r[ckg_pkg::IREF_SEL];
    stat_val[ckg_pkg::STAT_CLKST_HI:ckg_pkg::STAT_CLKST_LO] =
      (src_sel == 2'h3) ? 2'h0 : src_sel;
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      prdata  <= 32'h0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= 1'b0;
      if (rd_en) begin
        if (hit(paddr, ckg_pkg::OFS_SRC)) begin
          prdata <= place(src_r, ckg_pkg::OFS_SRC)
                    | place(bus_divider_r, ckg_pkg::OFS_BUS_DIVIDER)
                    | place(trim_r, ckg_pkg::OFS_TRIM)
                    | place(lock_r, ckg_pkg::OFS_LOCK);
        end else if (hit(paddr, ckg_pkg::OFS_STAT)) begin
          prdata <= place(stat_val, ckg_pkg::OFS_STAT)
                    | place(osc_r | {7'h0, osc_rdy_r}, ckg_pkg::OFS_OSC);
        end else if (hit(paddr, ckg_pkg::OFS_GATE0)) begin
          prdata <= {24'h0, gate_r[NGATE/2-1:0]};
        end else if (hit(paddr, ckg_pkg::OFS_GATE1)) begin
          prdata <= {24'h0, gate_r[NGATE-1:NGATE/2]};
        end else if (hit(paddr, ckg_pkg::OFS_PWR)) begin
          prdata <= {24'h0, pwr_r};
        end else begin
          prdata  <= 32'h0;
          pslverr <= 1'b1;
        end
      end else if (psel && !penable && pwrite) begin
        pslverr <= !(hit(paddr, ckg_pkg::OFS_SRC)
                     || hit(paddr, ckg_pkg::OFS_STAT)
                     || hit(paddr, ckg_pkg::OFS_GATE0)
                     || hit(paddr, ckg_pkg::OFS_GATE1)
                     || hit(paddr, ckg_pkg::OFS_PWR));
      end
    end
  end
endmodule

// ==== core/ckg_pkg.sv ====
// Constants for the clock source, oscillator and gating controller
// Behaviour
// - Both oscillator bits clear: bypass, input direct
// - Enable, select, gain low: low-power oscillator
// - Enable, select, gain high: high-gain oscillator
// - Bypass leaves crystal output pin free
// - Standalone 1 kHz clock runs in stop3
// - All gates enabled after reset
// - Gating write takes effect immediately; periph_clk_en here follows gate_r one clock later
// - Writes to gated peripheral are ignored
// - Stop gates every gated peripheral clock
// - Source select: loop, internal, external, reserved
// - Bus clock is source divided by divider
// - Reference divider power of two, range x32
// - Source control resets to 04h
// - Divider control resets to 20h
// - Trim control not initialised by reset
// - Status read-only, reads 10h after reset
// - Bus divider bits 7..5 divide 1..128
// - Loop reference select: 0 external, 1 internal
// - Stop-keep holds internal reference in stop
package ckg_pkg;
  localparam logic [15:0] OFS_SRC    = 16'h3038;
  localparam logic [15:0] OFS_BUS_DIVIDER   = 16'h3039;
  localparam logic [15:0] OFS_TRIM   = 16'h303a;
  localparam logic [15:0] OFS_LOCK   = 16'h303b;
  localparam logic [15:0] OFS_STAT   = 16'h303c;
  localparam logic [15:0] OFS_OSC    = 16'h303e;
  localparam logic [15:0] OFS_GATE0  = 16'h3040;
  localparam logic [15:0] OFS_GATE1  = 16'h3044;
  localparam logic [15:0] OFS_PWR    = 16'h3048;
  localparam logic [7:0]  RST_SRC    = 8'h04;
  localparam logic [7:0]  RST_BUS_DIVIDER   = 8'h20;
  localparam logic [7:0]  RST_LOCK   = 8'h00;
  localparam logic [7:0]  RST_STAT   = 8'h10;
  localparam logic [7:0]  RST_OSC    = 8'h00;
  localparam logic [7:0]  RST_GATE   = 8'hff;
  localparam int SRC_SEL_HI  = 7;
  localparam int SRC_SEL_LO  = 6;
  localparam int REFERENCE_DIVIDER_HI     = 5;
  localparam int REFERENCE_DIVIDER_LO     = 3;
  localparam int IREF_SEL    = 2;
  localparam int IREF_OEN    = 1;
  localparam int IREF_KEEP   = 0;
  localparam int BUS_DIVIDER_HI     = 7;
  localparam int BUS_DIVIDER_LO     = 5;
  localparam int OSC_EN      = 7;
  localparam int OSC_OS      = 4;
  localparam int OSC_HGO     = 3;
  localparam int OSC_RANGE   = 2;
  localparam int OSC_RDY     = 0;
  localparam int STAT_CLKST_HI = 3;
  localparam int STAT_CLKST_LO = 2;
  localparam int STAT_IREFST = 4;
  localparam logic [1:0] SRC_LOOP = 2'h0;
  localparam logic [1:0] SRC_IREF = 2'h1;
  localparam logic [1:0] SRC_EREF = 2'h2;
  localparam int RANGE_SHIFT = 5;
  localparam int OSC_START_CYC = 16;
  localparam int LPO_HZ      = 1000;
  localparam int MCLK_HZ     = 10000000;
  localparam int LPO_HALF_CYC = MCLK_HZ / (2 * LPO_HZ);
  typedef enum logic [3:0] {
    OSC_BYPASS = 4'h1,
    OSC_LOWPWR = 4'h2,
    OSC_HIGAIN = 4'h4,
    OSC_OTHER  = 4'h8
  } ckg_osc_mode_t;
endpackage

// ==== core/ckg_clk_div.sv ====
// Enable-pulse divider: one pulse every 2**exp source pulses
`timescale 1ns/1ps
module ckg_clk_div #(
  parameter int EW = 4
) (
  input  wire logic          mclk,
  input  wire logic          rstn,
  input  wire logic          src_tick,
  input  wire logic [EW-1:0] exp_sel,
  output logic               out_tick
);
  localparam int CW = (1 << EW);
  logic [CW-1:0] cnt_r;
  logic [CW-1:0] mask;

  always_comb begin
    mask = CW'((64'h1 << exp_sel) - 64'h1);
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      cnt_r    <= '0;
      out_tick <= 1'b0;
    end else begin
      out_tick <= 1'b0;
      if (src_tick) begin
        if ((cnt_r & mask) == mask) begin
          cnt_r    <= '0;
          out_tick <= 1'b1;
        end else begin
          cnt_r <= cnt_r + CW'(1);
        end
      end
    end
  end
endmodule

// ==== core/ckg_lpo.sv ====
// Standalone low-power 1 kHz clock from the main clock
`timescale 1ns/1ps
module ckg_lpo #(
  parameter int HALF = ckg_pkg::LPO_HALF_CYC
) (
  input  wire logic mclk,
  input  wire logic rstn,
  output logic      lpo_clk
);
  logic [15:0] cnt_r;
  // Free running: no stop input, so it keeps going in stop3
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      cnt_r   <= 16'h0;
      lpo_clk <= 1'b0;
    end else if (cnt_r == 16'(HALF - 1)) begin
      cnt_r   <= 16'h0;
      lpo_clk <= ~lpo_clk;
    end else begin
      cnt_r <= cnt_r + 16'h1;
    end
  end
endmodule

// ==== dv/ckg_ctrl_chk.sv ====
// Port checker for the clock controller
`timescale 1ns/1ps
module ckg_ctrl_chk #(
  parameter int NGATE = 16
) (
  input wire logic             mclk,
  input wire logic             rstn,
  input wire logic             psel,
  input wire logic             penable,
  input wire logic             pready,
  input wire logic             stop_mode,
  input wire logic             periph_wr_req,
  input wire logic [NGATE-1:0] periph_wr_sel,
  input wire logic [NGATE-1:0] periph_clk_en,
  input wire logic [NGATE-1:0] periph_wr_ok,
  input wire logic             osc_amp_en,
  input wire logic             osc_high_gain,
  input wire logic             crystal_output_pin_in_direct,
  input wire logic             crystal_output_pin_out_free,
  input wire logic             low_power_1khz_clock
);
  int   lpo_cnt;
  logic lpo_q;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  // Cycles since the slow clock last moved
  always_ff @(posedge mclk) begin
    lpo_q <= low_power_1khz_clock;
    if (!rstn || low_power_1khz_clock != lpo_q)
      lpo_cnt <= 0;
    else
      lpo_cnt <= lpo_cnt + 1;
  end
  sequence apb_setup;
    psel && !penable;
  endsequence
  sequence apb_answer;
    pready ##1 !pready;
  endsequence
  gates_reset_a: assert property ($rose(rstn) |-> &periph_clk_en)
    else $error("gates not all on after reset");
  wr_gate_a: assert property (1'b1 |=> periph_wr_ok ==
    ($past(periph_wr_sel) & $past(periph_clk_en) &
     {NGATE{$past(periph_wr_req) && !$past(stop_mode)}}))
    else $error("peripheral write pass wrong");
  apb_answer_a: assert property (apb_setup |=> apb_answer)
    else $error("bus answer not one cycle");
  bypass_amp_a: assert property (crystal_output_pin_in_direct |-> !osc_amp_en)
    else $error("amplifier on in bypass");
  gain_amp_a: assert property (osc_high_gain |-> osc_amp_en)
    else $error("high gain without amplifier");
  crystal_output_pin_free_a: assert property (crystal_output_pin_in_direct |-> crystal_output_pin_out_free)
    else $error("output pin held in bypass");
  stop_gate_a: assert property (stop_mode |=> periph_clk_en == '0)
    else $error("gate left open in stop");
  lpo_period_a: assert property (lpo_cnt < ckg_pkg::LPO_HALF_CYC + 2)
    else $error("slow clock stalled");
  lpo_fast_a: assert property ($changed(low_power_1khz_clock) |->
    $past(lpo_cnt) >= ckg_pkg::LPO_HALF_CYC - 2)
    else $error("slow clock too fast");
endmodule
bind ckg_ctrl ckg_ctrl_chk #(.NGATE(NGATE)) ckg_ctrl_chk_i (
  .mclk(mclk), .rstn(rstn), .psel(psel), .penable(penable),
  .pready(pready), .stop_mode(stop_mode), .periph_wr_req(periph_wr_req),
  .periph_wr_sel(periph_wr_sel), .periph_clk_en(periph_clk_en),
  .periph_wr_ok(periph_wr_ok), .osc_amp_en(osc_amp_en),
  .osc_high_gain(osc_high_gain), .crystal_output_pin_in_direct(crystal_output_pin_in_direct),
  .crystal_output_pin_out_free(crystal_output_pin_out_free),
  .low_power_1khz_clock(low_power_1khz_clock));

// ==== dv/ckg_xosc_model.sv ====
// External clock source: one tick every PER main clocks
`timescale 1ns/1ps
module ckg_xosc_model #(
  parameter int PER = 3
) (
  input  wire logic mclk,
  input  wire logic run,
  output logic      eref_tick
);
  int   cnt = 0;
  logic t   = 1'b0;
  assign eref_tick = t;
  // Silent unless the amplifier or the direct input takes the clock
  always @(posedge mclk) begin
    if (run !== 1'b1)
      cnt <= 0;
    else
      cnt <= (cnt == PER - 1) ? 0 : cnt + 1;
    t <= (run === 1'b1) && (cnt == PER - 1);
  end
endmodule

// ==== dv/ckg_ctrl_tb.sv ====
// Self-checking bench for the clock controller
`timescale 1ns/1ps
module ckg_ctrl_tb;
  localparam int N = 384;
  logic        mclk, rstn, psel, penable, pwrite, stop_mode, err, lq;
  logic        loop_tick, iref_tick, eref_tick, periph_wr_req;
  logic        pready, pslverr, amp, hg, direct, xfree, lpo, refint;
  logic        lrtick, btick, eren, irco;
  logic [1:0]  iph;
  logic [15:0] paddr, wsel, clk_en, wr_ok, m;
  logic [31:0] pwdata, prdata, rd;
  int          errors, samples_checked, seed, cyc, nb, nl, b, s, k, n, t, ni;
  ckg_ctrl #(.NGATE(16), .OSC_START(16)) ckg_ctrl_i (
    .mclk(mclk), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .stop_mode(stop_mode),
    .loop_tick(loop_tick), .iref_tick(iref_tick), .eref_tick(eref_tick),
    .periph_wr_req(periph_wr_req), .periph_wr_sel(wsel),
    .periph_clk_en(clk_en), .periph_wr_ok(wr_ok), .osc_amp_en(amp),
    .osc_high_gain(hg), .crystal_output_pin_in_direct(direct), .crystal_output_pin_out_free(xfree),
    .eref_clk_en(eren), .loop_ref_is_int(refint), .loop_ref_tick(lrtick),
    .bus_tick(btick), .iref_clk_out(irco), .low_power_1khz_clock(lpo));
  ckg_xosc_model #(.PER(3)) ckg_xosc_model_i (
    .mclk(mclk), .run(amp | direct), .eref_tick(eref_tick));
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    loop_tick <= ~loop_tick;
    iph <= iph + 2'h1;
    iref_tick <= (iph == 2'h3);
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      errors++;
      wrap_up();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  function automatic int near(input int sn, input int e);
    return (sn >= e - 1 && sn <= e + 1) ? e : sn;
  endfunction
  function automatic int expb(input int sv, input int bv);
    int p;
    p = (sv == 0) ? 2 : (sv == 1) ? 4 : (sv == 2) ? 3 : 0;
    return (p == 0) ? 0 : N / (p << bv);
  endfunction
  // One transfer; two idle cycles after it keep the strobes apart
  task automatic apb(input logic w, input logic [15:0] a,
                     input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    // Waits as long as the slave needs; only the bench timeout ends it
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
    @(posedge mclk);
  endtask
  task automatic meas();
    nb = 0;
    nl = 0;
    ni = 0;
    repeat (N) begin
      @(posedge mclk);
      nb += btick;
      nl += lrtick;
      ni += irco;
    end
  endtask
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    seed = 53;
    errors = 0;
    samples_checked = 0;
    cyc = 0;
    {rstn, psel, penable, pwrite, stop_mode, periph_wr_req} = 6'h0;
    {loop_tick, iref_tick, iph, paddr, wsel, pwdata} = '0;
    repeat (4) @(posedge mclk);
    rstn <= 1'b1;
    @(posedge mclk);
    chk(clk_en, 16'hffff);
    apb(0, ckg_pkg::OFS_SRC, 32'h0);
    chk(rd & 32'hff00ffff, {ckg_pkg::RST_LOCK, 8'h00, ckg_pkg::RST_BUS_DIVIDER,
        ckg_pkg::RST_SRC});
    apb(1, ckg_pkg::OFS_STAT, 32'hff);
    apb(0, ckg_pkg::OFS_STAT, 32'h0);
    chk(rd & 32'h00ff00ff, {8'h00, ckg_pkg::RST_OSC, 8'h00,
        ckg_pkg::RST_STAT});
    apb(0, ckg_pkg::OFS_GATE1, 32'h0);
    chk(rd[7:0], ckg_pkg::RST_GATE);
    apb(0, 16'h3050, 32'h0);
    chk(rd, 32'h0);
    chk(err, 1'b1);
    for (int i = 0; i < 8; i++) begin
      s = i % 4;
      b = (i == 0) ? 7 : (i == 1) ? 0 : ($random(seed) & 7);
      apb(1, ckg_pkg::OFS_SRC, {24'h0, s[1:0], 6'h04});
      apb(1, ckg_pkg::OFS_BUS_DIVIDER, {16'h0, b[2:0], 13'h0});
      meas();
      chk(near(nb, expb(s, b)), expb(s, b));
    end
    apb(1, ckg_pkg::OFS_SRC, 32'h10);
    meas();
    chk(near(nl, 32), 32);
    chk(refint, 1'b0);
    apb(1, ckg_pkg::OFS_OSC, 32'h00040000);
    apb(1, ckg_pkg::OFS_SRC, 32'h0);
    meas();
    chk(near(nl, 4), 4);
    apb(1, ckg_pkg::OFS_OSC, 32'h00980000);
    n = 0;
    do begin
      apb(0, ckg_pkg::OFS_STAT, 32'h0);
      n++;
    end while (rd[16] !== 1'b1 && n < 40);
    chk(rd[16], 1'b1);
    chk({amp, hg, direct, eren}, 4'b1101);
    apb(1, ckg_pkg::OFS_OSC, 32'h00900000);
    chk({amp, hg, direct, eren}, 4'b1001);
    apb(1, ckg_pkg::OFS_OSC, 32'h0);
    chk({amp, hg, direct, xfree, eren}, 5'b00110);
    m = 16'($random(seed));
    apb(1, ckg_pkg::OFS_GATE0, {24'h0, m[7:0]});
    apb(1, ckg_pkg::OFS_GATE1, {24'h0, m[15:8]});
    chk(clk_en, m);
    // Internal reference output: on in run, kept in stop only on request
    apb(1, ckg_pkg::OFS_SRC, 32'h06);
    meas();
    chk(near(ni, 96), 96);
    stop_mode <= 1'b1;
    meas();
    chk(near(ni, 0), 0);
    chk(clk_en, 16'h0);
    apb(1, ckg_pkg::OFS_SRC, 32'h07);
    meas();
    chk(near(ni, 96), 96);
    stop_mode <= 1'b0;
    @(posedge mclk);
    for (int i = 0; i < 8; i++) begin
      k = $random(seed) & 15;
      stop_mode <= i[2];
      wsel <= 16'h1 << k;
      periph_wr_req <= 1'b1;
      @(posedge mclk);
      periph_wr_req <= 1'b0;
      @(posedge mclk);
      chk(wr_ok, i[2] ? 16'h0 : (16'h1 << k) & m);
      @(posedge mclk);
    end
    // Slow clock must keep running while stopped
    t = 0;
    lq = lpo;
    repeat (11000) begin
      @(posedge mclk);
      if (lpo !== lq)
        t++;
      lq = lpo;
    end
    chk(t == 2 || t == 3, 1'b1);
    stop_mode <= 1'b0;
    wrap_up();
  end
endmodule
